// ==== core/mor_option_regs.v ====
// apb register bank for the upper memory controller option registers
//
// Overview of operation
// - each mask bit disables one 128k range
// - disable mask resets to zero
// - four bits choose one of sixteen configurations
// - ram select resets to 256k configuration
// - config one enables interleave, page, next-address
// - config one bit drops one page-hit wait
// - config one holds refresh options
// - config two: mode, fastreset, cas delay, clock
// - config two bit five is read-only
// - system port gives soft reset, a20 gate
`timescale 1ns/100ps
`default_nettype none
`include "mor_regs.vh"
module mor_option_regs
(
   input wire clk_i,
   input wire resetn_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [`MOR_ADDR_W-1:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output wire pready_o,
   output reg [31:0] prdata_o,
   output wire pslverr_o,
   input wire cfg2_status_i,
   output wire [4:0] range_disable_o,
   output wire [3:0] ram_config_o,
   output wire interleave_en_o,
   output wire page_mode_en_o,
   output wire next_address_en_o,
   output wire hit_read_wait_reduce_o,
   output wire [1:0] refresh_option_o,
   output wire extended_mode_o,
   output wire fast_reset_en_o,
   output wire [1:0] cas_delay_sel_o,
   output wire ras_timeout_clk_sel_o,
   output reg soft_reset_pulse_o,
   output wire address_line_twenty_gate_o
);
   reg [7:0] disable_mask;
   reg [7:0] ram_size_select;
   reg [7:0] config_one;
   reg [7:0] config_two;
   reg [7:0] system_control_port;
   reg ro_s1;
   reg ro_s2;
   reg ro_s3;
   reg ro_bit;
   wire wr_en;
   wire rd_en;
   wire [7:0] idx;
   wire hit;
   wire [7:0] wbyte;
   // per-register decode and write strobes
   wire sel_disable;
   wire sel_ramsel;
   wire sel_cfg1;
   wire sel_cfg2;
   wire sel_sysctl;
   wire wr_disable;
   wire wr_ramsel;
   wire wr_cfg1;
   wire wr_cfg2;
   wire wr_sysctl;
   wire reset_rise;
   wire setup_seen;
   // read mux and bus phase tracking
   reg [7:0] next_rdata;
   reg [1:0] bus_state;
   reg [1:0] next_bus_state;

   // apb phase tracker states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_SETUP = 2'b01;
   localparam [1:0] ST_ACCESS = 2'b10;

   // keeps stored bits outside the write mask
   function [7:0] merge;
      input [7:0] old_v;
      input [7:0] new_v;
      input [7:0] mask;
      begin
         merge = (old_v & ~mask) | (new_v & mask);
      end
   endfunction

   // true when the word index addresses the given register
   function index_match;
      input [7:0] index_v;
      input [7:0] target_v;
      begin
         index_match = (index_v == target_v);
      end
   endfunction

   // zero-extends a register byte onto the read bus
   function [31:0] widen;
      input [7:0] byte_v;
      begin
         widen = {24'h000000, byte_v};
      end
   endfunction

   // config two as software sees it, status in the read-only slot
   function [7:0] cfg2_view;
      input [7:0] stored_v;
      input status_v;
      begin
         cfg2_view = stored_v;
         cfg2_view[`MOR_CFG2_RO_BIT] = status_v;
      end
   endfunction

   assign idx = paddr_i[`MOR_ADDR_W-1:2];
   assign sel_disable = index_match(idx, `MOR_IDX_DISABLE);
   assign sel_ramsel = index_match(idx, `MOR_IDX_RAMSEL);
   assign sel_cfg1 = index_match(idx, `MOR_IDX_CFG1);
   assign sel_cfg2 = index_match(idx, `MOR_IDX_CFG2);
   assign sel_sysctl = index_match(idx, `MOR_IDX_SYSCTL);
   assign hit = sel_disable | sel_ramsel | sel_cfg1 | sel_cfg2 | sel_sysctl;
   // zero wait: every access completes in its first cycle
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;
   // a write lands only in an access phase that followed its setup
   assign setup_seen = (bus_state == ST_SETUP);
   assign wr_en = psel_i & penable_i & pwrite_i & hit & pstrb_i[0] & setup_seen;
   assign wr_disable = wr_en & sel_disable;
   assign wr_ramsel = wr_en & sel_ramsel;
   assign wr_cfg1 = wr_en & sel_cfg1;
   assign wr_cfg2 = wr_en & sel_cfg2;
   assign wr_sysctl = wr_en & sel_sysctl;
   assign reset_rise = wbyte[`MOR_SYS_RESET] & ~system_control_port[`MOR_SYS_RESET];
   // read data is fetched in the setup cycle
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;
   // only byte lane zero carries register data
   assign wbyte = pwdata_i[7:0];

   // read-only status bit sampled through three flops into a fourth that loads only when the last two agree
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ro_s1 <= 1'b0;
         ro_s2 <= 1'b0;
         ro_s3 <= 1'b0;
         ro_bit <= 1'b0;
      end
      else
      begin
         ro_s1 <= cfg2_status_i;
         ro_s2 <= ro_s1;
         ro_s3 <= ro_s2;
         if (ro_s2 == ro_s3)
            ro_bit <= ro_s3;
      end
   end

   // tracks the apb phase so an access is tied to its setup
   always @*
   begin
      next_bus_state = ST_IDLE;
      case (bus_state)
         ST_IDLE,
         ST_SETUP,
         ST_ACCESS:
         begin
            if (psel_i && !penable_i)
               next_bus_state = ST_SETUP;
            else if (psel_i && penable_i)
               next_bus_state = ST_ACCESS;
            else
               next_bus_state = ST_IDLE;
         end
         default:
         begin
            next_bus_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bus_state <= ST_IDLE;
      end
      else
      begin
         bus_state <= next_bus_state;
      end
   end

   // local memory disable mask
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         disable_mask <= `MOR_RST_DISABLE;
      end
      else if (wr_disable)
      begin
         disable_mask <= merge(disable_mask, wbyte, `MOR_WMASK_DISABLE);
      end
   end

   // ram size and organisation select
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ram_size_select <= `MOR_RST_RAMSEL;
      end
      else if (wr_ramsel)
      begin
         ram_size_select <= merge(ram_size_select, wbyte, `MOR_WMASK_RAMSEL);
      end
   end

   // configuration one
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         config_one <= `MOR_RST_CFG1;
      end
      else if (wr_cfg1)
      begin
         config_one <= merge(config_one, wbyte, `MOR_WMASK_CFG1);
      end
   end

   // configuration two, read-only slot never stored
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         config_two <= `MOR_RST_CFG2;
      end
      else if (wr_cfg2)
      begin
         config_two <= merge(config_two, wbyte, `MOR_WMASK_CFG2);
      end
   end

   // system control port
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         system_control_port <= `MOR_RST_SYSCTL;
      end
      else if (wr_sysctl)
      begin
         system_control_port <= merge(system_control_port, wbyte, `MOR_WMASK_SYSCTL);
      end
   end

   // rising write of the reset bit fires one pulse
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         soft_reset_pulse_o <= 1'b0;
      end
      else
      begin
         soft_reset_pulse_o <= wr_sysctl & reset_rise;
      end
   end

   // read mux for the addressed register
   always @*
   begin
      next_rdata = 8'h00;
      case (idx)
         `MOR_IDX_DISABLE:
            next_rdata = disable_mask;
         `MOR_IDX_RAMSEL:
            next_rdata = ram_size_select;
         `MOR_IDX_CFG1:
            next_rdata = config_one;
         `MOR_IDX_CFG2:
            next_rdata = cfg2_view(config_two, ro_bit);
         `MOR_IDX_SYSCTL:
            next_rdata = system_control_port;
         default:
            next_rdata = 8'h00;
      endcase
   end

   // read data registered in the setup cycle
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         prdata_o <= widen(`MOR_RST_DISABLE);
      end
      else if (rd_en)
      begin
         prdata_o <= widen(next_rdata);
      end
   end

   // decoded fields driving the memory controller
   assign range_disable_o = disable_mask[`MOR_DISABLE_W-1:0];
   assign ram_config_o = ram_size_select[`MOR_RAMSEL_W-1:0];
   // configuration one fields
   assign interleave_en_o = config_one[`MOR_CFG1_INTLV];
   assign page_mode_en_o = config_one[`MOR_CFG1_PAGE];
   assign next_address_en_o = config_one[`MOR_CFG1_NEXTADDR];
   assign hit_read_wait_reduce_o = config_one[`MOR_CFG1_HITLESS];
   assign refresh_option_o = config_one[`MOR_CFG1_REF_HI:`MOR_CFG1_REF_LO];
   // configuration two fields
   assign extended_mode_o = config_two[`MOR_CFG2_EXTMODE];
   assign fast_reset_en_o = config_two[`MOR_CFG2_FASTRST];
   assign cas_delay_sel_o = config_two[`MOR_CFG2_CASDLY_HI:`MOR_CFG2_CASDLY_LO];
   assign ras_timeout_clk_sel_o = config_two[`MOR_CFG2_RASCLK];
   // system control port fields
   assign address_line_twenty_gate_o = system_control_port[`MOR_SYS_A20];
endmodule // mor_option_regs
`default_nettype wire

// ==== include/mor_regs.vh ====
// register map and field constants for the memory option register bank
`ifndef MOR_REGS_VH
`define MOR_REGS_VH
`define MOR_IDX_DISABLE 8'h10
`define MOR_IDX_RAMSEL 8'h11
`define MOR_IDX_CFG1 8'h12
`define MOR_IDX_CFG2 8'h13
`define MOR_IDX_SYSCTL 8'h92
`define MOR_ADDR_W 10
`define MOR_RST_DISABLE 8'h00
`define MOR_RST_RAMSEL 8'h00
`define MOR_RST_CFG1 8'h00
`define MOR_RST_CFG2 8'h00
`define MOR_RST_SYSCTL 8'h00
`define MOR_WMASK_DISABLE 8'h1f
`define MOR_WMASK_RAMSEL 8'h0f
`define MOR_WMASK_CFG1 8'h3f
`define MOR_WMASK_CFG2 8'h1f
`define MOR_WMASK_SYSCTL 8'h03
`define MOR_CFG1_INTLV 0
`define MOR_CFG1_PAGE 1
`define MOR_CFG1_NEXTADDR 2
`define MOR_CFG1_HITLESS 3
`define MOR_CFG1_REF_LO 4
`define MOR_CFG1_REF_HI 5
`define MOR_CFG2_EXTMODE 0
`define MOR_CFG2_FASTRST 1
`define MOR_CFG2_CASDLY_LO 2
`define MOR_CFG2_CASDLY_HI 3
`define MOR_CFG2_RASCLK 4
`define MOR_CFG2_RO_BIT 5
`define MOR_SYS_RESET 0
`define MOR_SYS_A20 1
`define MOR_RAMSEL_W 4
`define MOR_DISABLE_W 5
`endif

// ==== verif/mor_option_regs_properties.sv ====
// checker for the option register bank ports
`timescale 1ns/100ps
`default_nettype none
module mor_props
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [9:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pslverr_o,
   input wire logic [4:0] range_disable_o,
   input wire logic soft_reset_pulse_o,
   input wire logic address_line_twenty_gate_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence wr(a);
      psel_i && penable_i && pwrite_i && paddr_i == a;
   endsequence
   AST_DIS: assert property (
      wr(10'h40) |=> range_disable_o == $past(pwdata_i[4:0])) else $error("mask load");
   AST_DHOLD: assert property (
      !(psel_i && penable_i && pwrite_i) |=> $stable(range_disable_o)) else $error("mask hold");
   AST_A20: assert property (
      wr(10'h248) |=> address_line_twenty_gate_o == $past(pwdata_i[1])) else $error("a20 load");
   AST_AHOLD: assert property (
      !(psel_i && penable_i && pwrite_i && paddr_i == 10'h248) |=>
         $stable(address_line_twenty_gate_o)) else $error("a20 hold");
   AST_PLS: assert property (
      soft_reset_pulse_o |=> !soft_reset_pulse_o) else $error("pulse long");
   AST_PCS: assert property (
      $rose(soft_reset_pulse_o) |-> $past(psel_i && pwrite_i)) else $error("pulse cause");
   AST_ERR: assert property (
      psel_i && penable_i && paddr_i == 10'h3fc |-> pslverr_o) else $error("no error");
   AST_OK: assert property (
      psel_i && penable_i && paddr_i == 10'h40 |-> !pslverr_o) else $error("false error");
endmodule // mor_props
bind mor_option_regs mor_props mor_props_i (.*);
`default_nettype wire

// ==== verif/tb.sv ====
// bench for the option register bank
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, cfg2_status_i = 0;
   logic [9:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rd;
   logic [3:0] pstrb_i = 4'hf, ram_config_o;
   logic pready_o, pslverr_o, er, interleave_en_o, page_mode_en_o, next_address_en_o;
   logic hit_read_wait_reduce_o, extended_mode_o, fast_reset_en_o, ras_timeout_clk_sel_o;
   logic soft_reset_pulse_o, address_line_twenty_gate_o;
   logic [4:0] range_disable_o;
   logic [1:0] refresh_option_o, cas_delay_sel_o;
   logic [9:0] ra [5] = '{10'h40, 10'h44, 10'h48, 10'h4c, 10'h248};
   logic [7:0] rw [5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h02};
   logic [7:0] rx [5] = '{8'h1f, 8'h0f, 8'h3f, 8'h1f, 8'h02};
   int fails = 0, cmp_count = 0;
   always #2.5 clk_i = ~clk_i;
   mor_option_regs mor_option_regs_i (.*);
   task automatic chk(input string n, input logic [31:0] e, s);
      cmp_count++;
      fails += (e !== s);
      if (e !== s)
         $display("[FAIL] %s exp %h got %h", n, e, s);
   endtask
   task automatic close_out;
      $display("compares %0d fails %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
         @(posedge clk_i);
      while (pready_o !== 1'b1 && ++n < 50);
      fails += (n >= 50);
      if (n >= 50)
         close_out();
      rd = prdata_o;
      er = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      foreach (ra[i])
      begin
         xfer(0, ra[i], 0);
         chk("reset", 0, rd);
         xfer(1, ra[i], rw[i]);
         xfer(0, ra[i], 0);
         chk("readback", rx[i], rd);
      end
      chk("fields", 32'h001f_ffff, {11'h000, range_disable_o, ram_config_o, interleave_en_o,
         page_mode_en_o, next_address_en_o, hit_read_wait_reduce_o, refresh_option_o,
         extended_mode_o, fast_reset_en_o, cas_delay_sel_o, ras_timeout_clk_sel_o,
         address_line_twenty_gate_o});
      xfer(1, 10'h248, 3);
      #1 chk("pulse", 1, soft_reset_pulse_o);
      @(posedge clk_i);
      cfg2_status_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      xfer(1, 10'h4c, 0);
      xfer(0, 10'h4c, 0);
      chk("ro bit", 32'h20, rd);
      xfer(0, 10'h3fc, 0);
      chk("unmapped", 1, er);
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("reset fields", 0, {11'h000, range_disable_o, ram_config_o, interleave_en_o,
         page_mode_en_o, next_address_en_o, hit_read_wait_reduce_o, refresh_option_o,
         extended_mode_o, fast_reset_en_o, cas_delay_sel_o, ras_timeout_clk_sel_o,
         address_line_twenty_gate_o});
      resetn_i <= 1'b1;
      xfer(0, 10'h40, 0);
      chk("reset mask", 0, rd);
      close_out();
   end
endmodule // tb
`default_nettype wire
